/* pdtc_core.v */
/*
  Packet DRAM transaction core: request packet capture, bank row tracking,
  scheduled store and fetch data packets.
  Assumes the forwarded clock runs well below mclk/4 and that the controller
  keeps the request spacing and one data packet on the bus at a time.
*/
`default_nettype none
`include "pdtc_map.vh"

module pdtc_core (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Forwarded clock pair
  input wire fclk_p,
  input wire fclk_n,
  // Request bus
  input wire [`PDTC_REQ_W-1:0] request_bus,
  // Data bus, three-signal form
  input wire [`PDTC_DQ_W-1:0] dq_in,
  output reg [`PDTC_DQ_W-1:0] dq_out,
  output reg dq_oe,
  // Status
  output reg [`PDTC_BANKS-1:0] bank_open,
  output reg [2:0] inflight
);

  function [`PDTC_ADDR_W-1:0] pdtc_addr;
    input [2:0] bank;
    input [`PDTC_ROW_W-1:0] row;
    input [`PDTC_COL_W-1:0] col;
    input [`PDTC_BEAT_W-1:0] beat;
    begin
      pdtc_addr = {bank, row, col, beat};
    end
  endfunction

  // ==========================================================
  // Pin synchronisers
  // Clock and data share the same two-stage delay, so each link edge still lines up with its windows.
  // Each leg of the pair has its own synchroniser; the legs are combined only once both are stable.
  reg [1:0] fclk_s_q;
  reg [1:0] fcln_s_q;
  reg fclk_d_q;
  reg [`PDTC_REQ_W-1:0] req_m_q, req_s_q;
  reg [`PDTC_DQ_W-1:0] dq_m_q, dq_s_q;
  wire link_lvl;
  wire win;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      fclk_s_q <= 2'h0;
      fcln_s_q <= 2'h0;
      fclk_d_q <= 1'b0;
      req_m_q <= {`PDTC_REQ_W{1'b0}};
      req_s_q <= {`PDTC_REQ_W{1'b0}};
      dq_m_q <= {`PDTC_DQ_W{1'b0}};
      dq_s_q <= {`PDTC_DQ_W{1'b0}};
    end else begin
      fclk_s_q <= {fclk_s_q[0], fclk_p};
      fcln_s_q <= {fcln_s_q[0], fclk_n};
      fclk_d_q <= link_lvl;
      req_m_q <= request_bus;
      req_s_q <= req_m_q;
      dq_m_q <= dq_in;
      dq_s_q <= dq_m_q;
    end
  end

  assign link_lvl = fclk_s_q[1] & ~fcln_s_q[1];
  assign win = link_lvl & ~fclk_d_q;

  // ==========================================================
  // Request packet capture
  reg phase_q;
  reg [`PDTC_REQ_W-1:0] first_q;
  wire [2:0] op = first_q[`PDTC_OP_HI:`PDTC_OP_LO];
  wire [2:0] cbank = first_q[`PDTC_BANK_HI:`PDTC_BANK_LO];
  wire [`PDTC_COL_W-1:0] ccol = req_s_q[`PDTC_COL_HI:`PDTC_COL_LO];
  wire pkt = win & phase_q;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_q <= 1'b0;
      first_q <= {`PDTC_REQ_W{1'b0}};
    end else if (win) begin
      if (!phase_q) begin
        first_q <= req_s_q;
        phase_q <= (req_s_q[`PDTC_OP_HI:`PDTC_OP_LO] != `PDTC_OP_NOP);
      end else begin
        phase_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Bank state
  // The sense amp array is modelled by latching the open row; column accesses index the cells through it.
  reg [`PDTC_ROW_W-1:0] open_row_q [0:`PDTC_BANKS-1];
  integer b;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      bank_open <= {`PDTC_BANKS{1'b0}};
      for (b = 0; b < `PDTC_BANKS; b = b + 1) begin
        open_row_q[b] <= {`PDTC_ROW_W{1'b0}};
      end
    end else if (pkt) begin
      if (op == `PDTC_OP_OPEN) begin
        bank_open[cbank] <= 1'b1;
        open_row_q[cbank] <= first_q[`PDTC_ROW_HI:`PDTC_ROW_LO];
      end else if (op == `PDTC_OP_CLOSE) begin
        bank_open[cbank] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Scheduled data packets
  // Four slots bound the transactions in flight; a column command finding all slots busy is dropped.
  reg [`PDTC_SLOTS-1:0] sv_q;
  reg [`PDTC_SLOTS-1:0] swr_q;
  reg [`PDTC_DLY_W-1:0] scnt_q [0:`PDTC_SLOTS-1];
  reg [`PDTC_ADDR_W-1:0] sad_q [0:`PDTC_SLOTS-1];
  reg eng_q, ewr_q;
  reg [`PDTC_ADDR_W-1:0] ead_q;
  reg [`PDTC_BEAT_W-1:0] beat_q;
  wire col_cmd = pkt & bank_open[cbank] & ((op == `PDTC_OP_STORE) | (op == `PDTC_OP_FETCH));
  wire [`PDTC_ADDR_W-1:0] mem_addr = ead_q | {{(`PDTC_ADDR_W-`PDTC_BEAT_W){1'b0}}, beat_q};
  wire [`PDTC_DQ_W-1:0] rd_data;
  reg fire;
  reg [1:0] fire_i;
  reg alloc;
  reg [1:0] alloc_i;
  integer s;
  integer t;

  always @* begin
    fire = 1'b0;
    fire_i = 2'h0;
    alloc = 1'b0;
    alloc_i = 2'h0;
    for (s = `PDTC_SLOTS - 1; s >= 0; s = s - 1) begin
      if (sv_q[s] && scnt_q[s] == {{(`PDTC_DLY_W-1){1'b0}}, 1'b1}) begin
        fire = win;
        fire_i = s[1:0];
      end
      if (!sv_q[s]) begin
        alloc = col_cmd;
        alloc_i = s[1:0];
      end
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sv_q <= {`PDTC_SLOTS{1'b0}};
      swr_q <= {`PDTC_SLOTS{1'b0}};
      for (t = 0; t < `PDTC_SLOTS; t = t + 1) begin
        scnt_q[t] <= {`PDTC_DLY_W{1'b0}};
        sad_q[t] <= {`PDTC_ADDR_W{1'b0}};
      end
    end else if (win) begin
      for (t = 0; t < `PDTC_SLOTS; t = t + 1) begin
        if (sv_q[t]) begin
          scnt_q[t] <= scnt_q[t] - {{(`PDTC_DLY_W-1){1'b0}}, 1'b1};
          if (fire && fire_i == t[1:0]) begin
            sv_q[t] <= 1'b0;
          end
        end
      end
      if (alloc) begin
        sv_q[alloc_i] <= 1'b1;
        swr_q[alloc_i] <= (op == `PDTC_OP_STORE);
        scnt_q[alloc_i] <= (op == `PDTC_OP_STORE) ? `PDTC_STORE_DATA_DELAY : `PDTC_FETCH_DATA_DELAY;
        sad_q[alloc_i] <= pdtc_addr(cbank, open_row_q[cbank], ccol, {`PDTC_BEAT_W{1'b0}});
      end
    end
  end

  // ==========================================================
  // Data packet engine
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      eng_q <= 1'b0;
      ewr_q <= 1'b0;
      ead_q <= {`PDTC_ADDR_W{1'b0}};
      beat_q <= {`PDTC_BEAT_W{1'b0}};
      dq_out <= {`PDTC_DQ_W{1'b0}};
      dq_oe <= 1'b0;
    end else if (win) begin
      if (eng_q) begin
        beat_q <= beat_q + {{(`PDTC_BEAT_W-1){1'b0}}, 1'b1};
        if (beat_q == `PDTC_LAST_BEAT) begin
          eng_q <= 1'b0;
        end
      end
      if (eng_q && !ewr_q) begin
        dq_out <= rd_data;
        dq_oe <= 1'b1;
      end else begin
        dq_oe <= 1'b0;
      end
      if (fire) begin
        eng_q <= 1'b1;
        ewr_q <= swr_q[fire_i];
        ead_q <= sad_q[fire_i];
        beat_q <= {`PDTC_BEAT_W{1'b0}};
      end
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      inflight <= 3'h0;
    end else begin
      inflight <= {2'h0, sv_q[0]} + {2'h0, sv_q[1]} + {2'h0, sv_q[2]} + {2'h0, sv_q[3]};
    end
  end

  pdtc_store u_store (
    .mclk(mclk),
    .wr_en(win & eng_q & ewr_q),
    .addr(mem_addr),
    .wr_data(dq_s_q),
    .rd_data(rd_data)
  );

endmodule
`default_nettype wire

/* pdtc_map.vh */
/*
  Constants for the packet DRAM transaction core: packet layout, command codes,
  array geometry and data delays.
  Assumes it is included by its bare name from the core and storage files.
*/
`ifndef PDTC_MAP_VH
`define PDTC_MAP_VH

// ==========================================================
// Request packet layout
`define PDTC_REQ_W 12
`define PDTC_OP_HI 11
`define PDTC_OP_LO 9
`define PDTC_BANK_HI 8
`define PDTC_BANK_LO 6
`define PDTC_ROW_HI 3
`define PDTC_ROW_LO 0
`define PDTC_COL_HI 2
`define PDTC_COL_LO 0

// ==========================================================
// Command codes
`define PDTC_OP_NOP 3'h0
`define PDTC_OP_OPEN 3'h1
`define PDTC_OP_STORE 3'h2
`define PDTC_OP_FETCH 3'h3
`define PDTC_OP_CLOSE 3'h4

// ==========================================================
// Geometry
`define PDTC_DQ_W 16
`define PDTC_BANKS 8
`define PDTC_ROW_W 4
`define PDTC_COL_W 3
`define PDTC_BEAT_W 4
`define PDTC_ADDR_W 14
`define PDTC_WORDS 16384
`define PDTC_LAST_BEAT 4'hf
`define PDTC_SLOTS 4

// ==========================================================
// Data delays in bit windows, at least two
`define PDTC_STORE_DATA_DELAY 5'h06
`define PDTC_FETCH_DATA_DELAY 5'h0c
`define PDTC_DLY_W 5

`endif

/* pdtc_store.v */
/*
  Cell array of the packet DRAM core: one word per data beat, addressed by
  bank, row, column and beat.
  Assumes one write strobe per bit window from the core; read is combinational.
*/
`default_nettype none
`include "pdtc_map.vh"

module pdtc_store (
  // Clock
  input wire mclk,
  // Write port
  input wire wr_en,
  input wire [`PDTC_ADDR_W-1:0] addr,
  input wire [`PDTC_DQ_W-1:0] wr_data,
  // Read port
  output wire [`PDTC_DQ_W-1:0] rd_data
);

  reg [`PDTC_DQ_W-1:0] cells [0:`PDTC_WORDS-1];

  always @(posedge mclk) begin
    if (wr_en) begin
      cells[addr] <= wr_data;
    end
  end

  assign rd_data = cells[addr];

endmodule
`default_nettype wire

/* pdtc_core_asserts.sv */
/*
  Checker for the packet DRAM core: output timing against link windows.
  Assumes it is bound to pdtc_core and sees only its ports.
*/
`default_nettype none
module pdtc_core_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Link
  input wire logic fclk_p,
  input wire logic fclk_n,
  // Outputs watched
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  input wire logic [7:0] bank_open,
  input wire logic [2:0] inflight
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Window tracking
  // The same three-stage sampling as the core keeps both views of a window within a cycle.
  logic [2:0] lk_q;
  logic [2:0] since_q;
  logic [4:0] n_q;
  wire win = lk_q[1] & ~lk_q[2];
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      lk_q <= 3'h0;
      since_q <= 3'h7;
      n_q <= 5'h00;
    end else begin
      lk_q <= {lk_q[1:0], fclk_p & ~fclk_n};
      since_q <= win ? 3'h0 : (since_q == 3'h7 ? since_q : since_q + 3'h1);
      n_q <= !dq_oe ? 5'h00 : n_q + {4'h0, win};
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_beat_count: assert property ($fell(dq_oe) |-> n_q == 5'h10) else $error("read packet length wrong");
  chk_out_stands: assert property ($changed(dq_out) |-> since_q <= 3'h3) else $error("read data moved off window");
  chk_oe_holds: assert property ($rose(dq_oe) |=> dq_oe [*8]) else $error("read enable too short");
  chk_oe_on_window: assert property ($rose(dq_oe) |-> since_q <= 3'h3) else $error("read start off window");
  // The slot frees one window before the beat starts, so the booking is looked for one window back.
  chk_fetch_booked: assert property ($rose(dq_oe) |-> $past(inflight, 8) != 3'h0) else $error("read without booking");
  chk_inflight_cap: assert property ($changed(inflight) |-> inflight <= 3'h4 && since_q == 3'h1) else $error("bad slot count");
  chk_bank_timing: assert property ($changed(bank_open) |-> since_q <= 3'h3) else $error("bank flag off window");
  chk_bank_single: assert property ($onehot0(bank_open ^ $past(bank_open))) else $error("two banks moved");
  cover property ($fell(dq_oe));
  cover property (inflight == 3'h1);
  cover property (bank_open == 8'ha9);
endmodule
bind pdtc_core pdtc_core_asserts u_chk (.mclk(mclk), .rst(rst), .fclk_p(fclk_p), .fclk_n(fclk_n),
  .dq_out(dq_out), .dq_oe(dq_oe), .bank_open(bank_open), .inflight(inflight));
`default_nettype wire

/* pdtc_ctrl_model.sv */
/*
  Memory controller model: plays a window schedule of request and data words.
  Assumes the bench fills req_s and ds before calling play.
*/
`default_nettype none
module pdtc_ctrl_model (
  // Clock
  input wire logic mclk,
  // Link and buses
  output logic fclk_p,
  output logic fclk_n,
  output logic [11:0] request_bus,
  output logic [15:0] dq_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Schedule and player
  logic [11:0] req_s [0:511];
  logic [16:0] ds [0:511];
  initial begin
    fclk_p = 1'b0;
    fclk_n = 1'b1;
    request_bus = 12'h000;
    dq_in = 16'h5a5a;
    for (int i = 0; i < 512; i++) begin
      req_s[i] = 12'h000;
      ds[i] = 17'h00000;
    end
  end
  // The link clock stands still between calls; an idle data bus toggles so stale beats never match.
  task play(input int a, input int b);
    @(posedge mclk);
    for (int w = a; w < b; w++) begin
      #2;
      fclk_p = 1'b0;
      fclk_n = 1'b1;
      request_bus = req_s[w];
      dq_in = ds[w][16] ? ds[w][15:0] : ~dq_in;
      repeat (4) @(posedge mclk);
      #2;
      fclk_p = 1'b1;
      fclk_n = 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask
endmodule
`default_nettype wire

/* pdtc_core_bench.sv */
/*
  Testbench for the packet DRAM core: stores, fetches, refusals, interleaved banks.
  Assumes the controller model plays one window per 200 ns.
*/
`default_nettype none
`include "pdtc_map.vh"
module pdtc_core_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Harness
  logic mclk = 1'b0;
  logic rst = 1'b1;
  wire fclk_p, fclk_n, dq_oe;
  wire [11:0] req_bus;
  wire [15:0] dq_in, dq_out;
  wire [7:0] bank_open;
  wire [2:0] inflight;
  logic [15:0] exp_q [$];
  logic [15:0] md [0:1023];
  logic [15:0] seed = 16'hd19c;
  int error_cnt = 0;
  int total_checks = 0;
  initial forever #12.5 mclk = ~mclk;
  pdtc_core dut (.mclk(mclk), .rst(rst), .fclk_p(fclk_p), .fclk_n(fclk_n), .request_bus(req_bus),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .bank_open(bank_open), .inflight(inflight));
  pdtc_ctrl_model ctl (.mclk(mclk), .fclk_p(fclk_p), .fclk_n(fclk_n), .request_bus(req_bus), .dq_in(dq_in));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task cmd(input int w, input logic [2:0] op, input logic [2:0] b, input logic [3:0] a);
    ctl.req_s[w] = {op, b, 2'h0, a};
    ctl.req_s[w + 1] = {9'h000, a[2:0]};
  endtask
  task store(input int w, input logic [2:0] b, input logic [2:0] c);
    cmd(w, `PDTC_OP_STORE, b, {1'b0, c});
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      // Beat 0 is taken one window after the store delay runs out behind the command's second window.
      ctl.ds[w + 8 + k] = {1'b1, seed};
      md[{b, c, k[3:0]}] = seed;
    end
  endtask
  task fetch(input int w, input logic [2:0] b, input logic [2:0] c);
    cmd(w, `PDTC_OP_FETCH, b, {1'b0, c});
    for (int k = 0; k < 16; k++) exp_q.push_back(md[{b, c, k[3:0]}]);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // Result watcher
  always @(posedge fclk_p) begin
    if (dq_oe === 1'b1) begin
      if (exp_q.size() == 0) chk("dq_out extra", dq_oe, 1'b0);
      else chk("dq_out", dq_out, exp_q.pop_front());
    end
  end
  initial begin
    #120us;
    error_cnt++;
    close_out;
  end
  // ==========================================================
  // Scenarios
  initial begin
    repeat (10) @(posedge mclk);
    #2 rst = 1'b0;
    cmd(0, `PDTC_OP_OPEN, 3'h2, 4'h5);
    store(2, 3'h2, 3'h1);
    store(18, 3'h2, 3'h6);
    fetch(40, 3'h2, 3'h6);
    fetch(58, 3'h2, 3'h1);
    cmd(90, `PDTC_OP_CLOSE, 3'h2, 4'h0);
    cmd(92, `PDTC_OP_FETCH, 3'h2, 4'h3);
    ctl.play(0, 4);
    #2;
    chk("bank_open", {8'h00, bank_open}, 16'h0004);
    chk("inflight", {13'h0000, inflight}, 16'h0001);
    ctl.play(4, 110);
    chk("bank_open", {8'h00, bank_open}, 16'h0000);
    chk("pending", 16'(exp_q.size()), 16'h0000);
    $display("single bank test done");
    for (int i = 0; i < 4; i++) begin
      cmd(110 + 2 * i, `PDTC_OP_OPEN, 2 * i + 1 - (i == 0), i + 1);
      store(118 + 16 * i, 2 * i + 1 - (i == 0), i + 2);
      fetch(190 + 18 * i, 2 * i + 1 - (i == 0), i + 2);
      cmd(276 + 2 * i, `PDTC_OP_CLOSE, 2 * i + 1 - (i == 0), 4'h0);
    end
    ctl.play(110, 118);
    chk("bank_open", {8'h00, bank_open}, 16'h00a9);
    ctl.play(118, 290);
    chk("bank_open", {8'h00, bank_open}, 16'h0000);
    chk("pending", 16'(exp_q.size()), 16'h0000);
    $display("interleave test done");
    close_out;
  end
endmodule
`default_nettype wire
